// ==== pspb_consts.svh ====
// constants for the pixel shader payload builder: offsets, fields, resets
`ifndef PSPB_CONSTS_SVH
`define PSPB_CONSTS_SVH

// ==========================================================
// apb register offsets (byte addresses)
`define PSPB_ADDR_CTRL      12'h000
`define PSPB_ADDR_CC_PTR    12'h004
`define PSPB_ADDR_SAMP_PTR  12'h008
`define PSPB_ADDR_BIND_PTR  12'h00c
`define PSPB_ADDR_SCR_PTR   12'h010
`define PSPB_ADDR_STATUS    12'h014
`define PSPB_ADDR_THREAD    12'h018

// ==========================================================
// control register fields
`define PSPB_CTRL_SIMD16    0
`define PSPB_CTRL_NS_HI     3
`define PSPB_CTRL_NS_LO     1
`define PSPB_CTRL_CONTIG    4
`define PSPB_CTRL_DEPTH_RT  5
`define PSPB_CTRL_COVMASK_RT 6
`define PSPB_CTRL_BARY_HI   12
`define PSPB_CTRL_BARY_LO   7
`define PSPB_CTRL_SRC_DEPTH 13
`define PSPB_CTRL_SRC_W     14
`define PSPB_CTRL_RESET     32'h0000_0000
`define PSPB_PTR_RESET      32'h0000_0000

// ==========================================================
// status register fields
`define PSPB_STAT_BUSY      0
`define PSPB_STAT_REFUSED   1
`define PSPB_STAT_REGS_HI   13
`define PSPB_STAT_REGS_LO   8

// ==========================================================
// header field positions and limits
`define PSPB_SCRATCH_MAX    4'hb
`define PSPB_NS_MAX         3'h4
`define PSPB_H0_VP_HI       30
`define PSPB_H0_VP_LO       27
`define PSPB_H0_ARR_HI      26
`define PSPB_H0_ARR_LO      16
`define PSPB_H0_FACE        15
`define PSPB_H0_DEPTH       13
`define PSPB_H0_COVMASK     12
`define PSPB_H0_PAIR_HI     7
`define PSPB_H0_PAIR_LO     6

`endif

// ==== pspb_pkg.sv ====
// types shared by the pixel shader payload builder
package pspb_pkg;

	typedef enum logic {PSPB_IDLE, PSPB_ISSUE} pspb_state_type;

	typedef struct packed {
		pspb_state_type  st;
		logic [31:0]     ctrl;
		logic [31:0]     cc_ptr;
		logic [31:0]     samp_ptr;
		logic [31:0]     bind_ptr;
		logic [31:0]     scr_ptr;
		logic            refused;
		logic [23:0]     thread_cnt;
		logic [7:0]      tag;
		logic            simd16;
		logic [2:0]      ns_log2;
		logic [2:0]      pair_idx;
		logic [2:0]      left;
		logic [1:0]      step;
		logic [23:0]     prim_id;
		logic            back;
		logic [3:0]      vp;
		logic [10:0]     arr;
		logic [5:0]      total_regs;
		logic [5:0]      depth_reg;
		logic [5:0]      w_reg;
		logic [7:0][31:0] hdr;
		logic [3:0][1:0] g_subspan;
		logic [3:0][3:0] g_sample;
	} pspb_regs_type;

endpackage : pspb_pkg

// ==== pspb_slot_map.sv ====
// slot group to subspan and sample mapping for one dispatch
`timescale 1ns/1ps
module pspb_slot_map
	import pspb_pkg::*;
(
	input  wire logic             simd16,
	input  wire logic [2:0]       ns_log2,
	input  wire logic [2:0]       pair_idx,
	output logic      [3:0][1:0]  grp_subspan,
	output logic      [3:0][3:0]  grp_sample
);

	// ==========================================================
	// per-group decode
	function automatic logic [5:0] pspb_map_group(input logic s16, input logic [2:0] nsl,
		input logic [2:0] pair, input logic [1:0] g);
		logic [2:0] lg;
		logic [3:0] nmask;
		lg = s16 ? 3'h2 : 3'h1;
		nmask = 4'((5'h01 << nsl) - 5'h01);
		if (!s16 && g[1])
			pspb_map_group = 6'h00;
		else if (nsl <= lg)
			// all samples fit in one dispatch, pair index stays zero
			pspb_map_group = {2'(4'(g) >> nsl), 4'(g) & nmask};
		else
			pspb_map_group = {2'h0, 4'({pair, 1'b0}) + 4'(g)};
	endfunction : pspb_map_group

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_grp
			assign {grp_subspan[gi], grp_sample[gi]} =
				pspb_map_group(simd16, ns_log2, pair_idx, 2'(gi));
		end
	endgenerate

endmodule : pspb_slot_map

// ==== pspb_phase_map.sv ====
// register numbering of the optional payload phases
`timescale 1ns/1ps
module pspb_phase_map
	import pspb_pkg::*;
(
	input  wire logic       simd16,
	input  wire logic [5:0] bary_en,
	input  wire logic       depth_en,
	input  wire logic       w_en,
	output logic      [5:0] depth_reg,
	output logic      [5:0] w_reg,
	output logic      [5:0] total_regs
);

	// ==========================================================
	// phases packed in fixed order, skipped ones close the gap
	always_comb
	begin
		logic [5:0] n;
		logic [5:0] per;
		per = simd16 ? 6'h02 : 6'h01;
		n = 6'h02;
		for (int i = 0; i < 6; i++)
			if (bary_en[i])
				n = n + 6'(per << 1);
		depth_reg = n;
		if (depth_en)
			n = n + per;
		w_reg = n;
		if (w_en)
			n = n + per;
		total_regs = n;
	end

endmodule : pspb_phase_map

// ==== pspb_builder.sv ====
// pixel shader dispatch and payload header builder with apb registers
`timescale 1ns/1ps
`include "pspb_consts.svh"
module pspb_builder
	import pspb_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire logic [23:0]       req_prim_thread_id,
	input  wire logic              req_back_facing,
	input  wire logic [3:0]        req_viewport_index,
	input  wire logic [10:0]       req_array_index,
	output logic                   disp_valid,
	input  wire logic              disp_ready,
	output logic      [7:0][31:0]  disp_header,
	output logic      [2:0]        first_sample_pair_index,
	output logic      [7:0]        thread_resource_tag,
	output logic      [3:0][1:0]   slot_group_subspan,
	output logic      [3:0][3:0]   slot_group_sample,
	output logic      [5:0]        disp_payload_regs,
	output logic      [5:0]        disp_depth_reg,
	output logic      [5:0]        disp_w_reg
);

	// ==========================================================
	// state
	pspb_regs_type   r_q;
	pspb_regs_type   r_d;
	logic [2:0]      map_pair;
	logic            map_simd16;
	logic [2:0]      map_ns;
	logic [3:0][1:0] map_subspan;
	logic [3:0][3:0] map_sample;
	logic [5:0]      ph_depth;
	logic [5:0]      ph_w;
	logic [5:0]      ph_total;
	logic            wr_en;
	logic            rd_hit;
	logic            accept;
	logic            issue_done;

	// ==========================================================
	// helpers
	function automatic logic pspb_mapped(input logic [11:0] a);
		case (a)
			`PSPB_ADDR_CTRL, `PSPB_ADDR_CC_PTR, `PSPB_ADDR_SAMP_PTR,
			`PSPB_ADDR_BIND_PTR, `PSPB_ADDR_SCR_PTR, `PSPB_ADDR_STATUS,
			`PSPB_ADDR_THREAD:
				pspb_mapped = 1'b1;
			default:
				pspb_mapped = 1'b0;
		endcase
	endfunction : pspb_mapped

	// header starts from zero so every reserved bit stays clear
	function automatic logic [7:0][31:0] pspb_build(input pspb_regs_type s);
		logic [7:0][31:0] h;
		h = '0;
		h[7][23:0] = s.prim_id;
		h[6][23:0] = s.thread_cnt;
		h[5][31:10] = s.scr_ptr[31:10];
		h[5][7:0] = s.tag;
		h[4][31:5] = s.bind_ptr[31:5];
		h[3][31:5] = s.samp_ptr[31:5];
		h[3][3:0] = s.samp_ptr[3:0];
		h[1][31:6] = s.cc_ptr[31:6];
		h[0][`PSPB_H0_VP_HI:`PSPB_H0_VP_LO] = s.vp;
		h[0][`PSPB_H0_ARR_HI:`PSPB_H0_ARR_LO] = s.arr;
		h[0][`PSPB_H0_FACE] = s.back;
		h[0][`PSPB_H0_DEPTH] = s.ctrl[`PSPB_CTRL_DEPTH_RT];
		h[0][`PSPB_H0_COVMASK] = s.ctrl[`PSPB_CTRL_COVMASK_RT];
		h[0][`PSPB_H0_PAIR_HI:`PSPB_H0_PAIR_LO] = s.pair_idx[1:0];
		pspb_build = h;
	endfunction : pspb_build

	// ==========================================================
	// sub-blocks
	pspb_slot_map u_slot_map (
		.simd16      (map_simd16),
		.ns_log2     (map_ns),
		.pair_idx    (map_pair),
		.grp_subspan (map_subspan),
		.grp_sample  (map_sample)
	);

	pspb_phase_map u_phase_map (
		.simd16     (r_q.ctrl[`PSPB_CTRL_SIMD16]),
		.bary_en    (r_q.ctrl[`PSPB_CTRL_BARY_HI:`PSPB_CTRL_BARY_LO]),
		.depth_en   (r_q.ctrl[`PSPB_CTRL_SRC_DEPTH]),
		.w_en       (r_q.ctrl[`PSPB_CTRL_SRC_W]),
		.depth_reg  (ph_depth),
		.w_reg      (ph_w),
		.total_regs (ph_total)
	);

	// ==========================================================
	// apb slave, zero wait states
	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;
	assign rd_hit  = pspb_mapped(paddr);
	assign pslverr = psel && penable && !rd_hit;

	always_comb
	begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite)
			case (paddr)
				`PSPB_ADDR_CTRL:     prdata = r_q.ctrl;
				`PSPB_ADDR_CC_PTR:   prdata = r_q.cc_ptr;
				`PSPB_ADDR_SAMP_PTR: prdata = r_q.samp_ptr;
				`PSPB_ADDR_BIND_PTR: prdata = r_q.bind_ptr;
				`PSPB_ADDR_SCR_PTR:  prdata = r_q.scr_ptr;
				`PSPB_ADDR_STATUS:
				begin
					prdata[`PSPB_STAT_BUSY] = (r_q.st == PSPB_ISSUE);
					prdata[`PSPB_STAT_REFUSED] = r_q.refused;
					prdata[`PSPB_STAT_REGS_HI:`PSPB_STAT_REGS_LO] = ph_total;
				end
				`PSPB_ADDR_THREAD:   prdata = {8'h00, r_q.thread_cnt};
				default:             prdata = 32'h0000_0000;
			endcase
	end

	// ==========================================================
	// dispatch handshakes
	assign req_ready  = (r_q.st == PSPB_IDLE);
	assign accept     = req_valid && req_ready;
	assign disp_valid = (r_q.st == PSPB_ISSUE);
	assign issue_done = disp_valid && disp_ready;

	// mapping is looked up for the pair index about to be registered
	assign map_pair   = r_d.pair_idx;
	assign map_simd16 = r_d.simd16;
	assign map_ns     = r_d.ns_log2;

	// ==========================================================
	// next state
	always_comb
	begin
		logic [2:0] lg;
		logic       build;
		r_d = r_q;
		build = 1'b0;
		lg = 3'h0;
		if (wr_en)
			case (paddr)
				`PSPB_ADDR_CTRL:     r_d.ctrl = pwdata;
				`PSPB_ADDR_CC_PTR:   r_d.cc_ptr = pwdata;
				`PSPB_ADDR_SAMP_PTR:
				begin
					r_d.samp_ptr = pwdata;
					// codes above the largest size saturate
					if (pwdata[3:0] > `PSPB_SCRATCH_MAX)
						r_d.samp_ptr[3:0] = `PSPB_SCRATCH_MAX;
				end
				`PSPB_ADDR_BIND_PTR: r_d.bind_ptr = pwdata;
				`PSPB_ADDR_SCR_PTR:  r_d.scr_ptr = pwdata;
				`PSPB_ADDR_STATUS:
					if (pwdata[`PSPB_STAT_REFUSED])
						r_d.refused = 1'b0;
				default:             r_d.ctrl = r_q.ctrl;
			endcase
		case (r_q.st)
			PSPB_IDLE:
				if (accept)
				begin
					if (r_q.ctrl[`PSPB_CTRL_CONTIG])
						// contiguous formats are built elsewhere; set wins over clear
						r_d.refused = 1'b1;
					else
					begin
						r_d.simd16 = r_q.ctrl[`PSPB_CTRL_SIMD16];
						r_d.ns_log2 = r_q.ctrl[`PSPB_CTRL_NS_HI:`PSPB_CTRL_NS_LO];
						if (r_d.ns_log2 > `PSPB_NS_MAX)
							r_d.ns_log2 = `PSPB_NS_MAX;
						lg = r_d.simd16 ? 3'h2 : 3'h1;
						r_d.pair_idx = 3'h0;
						r_d.step = r_d.simd16 ? 2'h2 : 2'h1;
						if (r_d.ns_log2 <= lg)
							r_d.left = 3'h0;
						else
							r_d.left = 3'((4'h1 << (r_d.ns_log2 - lg)) - 4'h1);
						r_d.prim_id = req_prim_thread_id;
						r_d.back = req_back_facing;
						r_d.vp = req_viewport_index;
						r_d.arr = req_array_index;
						r_d.total_regs = ph_total;
						r_d.depth_reg = ph_depth;
						r_d.w_reg = ph_w;
						r_d.st = PSPB_ISSUE;
						build = 1'b1;
					end
				end
			PSPB_ISSUE:
				if (issue_done)
				begin
					r_d.thread_cnt = r_q.thread_cnt + 24'h00_0001;
					r_d.tag = r_q.tag + 8'h01;
					if (r_q.left == 3'h0)
						r_d.st = PSPB_IDLE;
					else
					begin
						r_d.pair_idx = r_q.pair_idx + 3'(r_q.step);
						r_d.left = r_q.left - 3'h1;
						build = 1'b1;
					end
				end
			default:
				r_d.st = PSPB_IDLE;
		endcase
		if (build)
		begin
			r_d.hdr = pspb_build(r_d);
			r_d.g_subspan = map_subspan;
			r_d.g_sample = map_sample;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r_q <= '0;
			r_q.st <= PSPB_IDLE;
			r_q.ctrl <= `PSPB_CTRL_RESET;
			r_q.cc_ptr <= `PSPB_PTR_RESET;
		end
		else
			r_q <= r_d;
	end

	// ==========================================================
	// outputs
	assign disp_header             = r_q.hdr;
	assign first_sample_pair_index = r_q.pair_idx;
	assign thread_resource_tag     = r_q.tag;
	assign slot_group_subspan      = r_q.g_subspan;
	assign slot_group_sample       = r_q.g_sample;
	assign disp_payload_regs       = r_q.total_regs;
	assign disp_depth_reg          = r_q.depth_reg;
	assign disp_w_reg              = r_q.w_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_hdr2_zero: assert property (disp_valid |-> disp_header[2] == 32'h0000_0000)
		else $error("header dword 2 not zero");

	chk_reserved_bits: assert property (disp_valid |-> disp_header[0][31] == 1'b0 &&
		disp_header[0][14] == 1'b0 && disp_header[0][11:8] == 4'h0 &&
		disp_header[0][5:0] == 6'h00 && disp_header[7][31:24] == 8'h00 &&
		disp_header[5][9:8] == 2'h0 && disp_header[1][5:0] == 6'h00)
		else $error("reserved header bit set");

	chk_pair_field: assert property (disp_valid |->
		disp_header[0][7:6] == first_sample_pair_index[1:0])
		else $error("pair index field mismatch");

	chk_thread_count: assert property (disp_valid && disp_ready |=>
		r_q.thread_cnt == $past(r_q.thread_cnt) + 24'h00_0001)
		else $error("thread counter did not advance");

	chk_thread_in_hdr: assert property (disp_valid |->
		disp_header[6][23:0] == r_q.thread_cnt)
		else $error("thread id not in dword 6");

	chk_pair_step: assert property (disp_valid && disp_ready && r_q.left != 3'h0 |=>
		disp_valid && first_sample_pair_index ==
		$past(first_sample_pair_index) + (r_q.simd16 ? 3'h2 : 3'h1))
		else $error("pair index step wrong");

	chk_contig_refused: assert property (accept && r_q.ctrl[`PSPB_CTRL_CONTIG] |=>
		!disp_valid && r_q.refused)
		else $error("contiguous request dispatched");

	chk_two_sample_map: assert property (disp_valid && !r_q.simd16 && r_q.ns_log2 == 3'h1 |->
		slot_group_sample[0] == 4'h0 && slot_group_sample[1] == 4'h1 &&
		slot_group_subspan[1] == 2'h0)
		else $error("two-sample slot map wrong");

	chk_one_sample_map: assert property (disp_valid && !r_q.simd16 && r_q.ns_log2 == 3'h0 |->
		slot_group_subspan[1] == 2'h1 && slot_group_sample[1] == 4'h0)
		else $error("one-sample slot map wrong");

	chk_wide_eight: assert property (accept && !r_q.ctrl[`PSPB_CTRL_CONTIG] &&
		r_q.ctrl[`PSPB_CTRL_SIMD16] && r_q.ctrl[3:1] == 3'h3 |=>
		disp_valid && r_q.left == 3'h1 && first_sample_pair_index == 3'h0)
		else $error("16-wide 8-sample count wrong");

	chk_reserved_ptrs: assert property (disp_valid |-> disp_header[6][31:24] == 8'h00 &&
		disp_header[4][4:0] == 5'h00 && disp_header[3][4] == 1'b0)
		else $error("reserved pointer bits set");

	chk_tag_in_hdr: assert property (disp_valid |->
		disp_header[5][7:0] == thread_resource_tag)
		else $error("tag not in dword 5");

	chk_scratch_code: assert property (disp_valid |->
		disp_header[3][3:0] <= `PSPB_SCRATCH_MAX)
		else $error("scratch size code out of range");

	cov_multi_dispatch: cover property (disp_valid && disp_ready && r_q.left != 3'h0);
	cov_refused: cover property (accept && r_q.ctrl[`PSPB_CTRL_CONTIG]);
	cov_eight_pairs: cover property (disp_valid && first_sample_pair_index == 3'h7);
	cov_wide_pairs: cover property (disp_valid && r_q.simd16 && first_sample_pair_index == 3'h6);

endmodule : pspb_builder

// ==== pspb_disp_sink.sv ====
// dispatch receiver model: takes dispatches after a programmable stall
`timescale 1ns/1ps
module pspb_disp_sink
	import pspb_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       disp_valid,
	input  wire logic [3:0] stall,
	output logic            disp_ready
);
	// ==========================================================
	// acceptance pacing
	logic [3:0] wait_q;

	// ready only ever follows a seen offer, never offered in advance
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_q     <= 4'h0;
			disp_ready <= 1'b0;
		end
		else if (disp_ready)
		begin
			wait_q     <= 4'h0;
			disp_ready <= 1'b0;
		end
		else if (disp_valid)
		begin
			if (wait_q >= stall)
				disp_ready <= 1'b1;
			else
				wait_q <= wait_q + 4'h1;
		end
	end
endmodule : pspb_disp_sink

// ==== tb.sv ====
// self-checking testbench for the payload builder
`timescale 1ns/1ps
`include "pspb_consts.svh"
module tb
	import pspb_pkg::*;
;
	// ==========================================================
	// signals
	logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata, rd;
	logic             req_valid, req_ready, req_back_facing, disp_valid, disp_ready;
	logic [23:0]      req_prim_thread_id;
	logic [3:0]       req_viewport_index, stall;
	logic [10:0]      req_array_index;
	logic [7:0][31:0] disp_header;
	logic [2:0]       first_sample_pair_index;
	logic [7:0]       thread_resource_tag;
	logic [3:0][1:0]  slot_group_subspan;
	logic [3:0][3:0]  slot_group_sample;
	logic [5:0]       disp_payload_regs, disp_depth_reg, disp_w_reg;
	int               n_errors, tests_run, exp_tid;

	pspb_builder pspb_builder_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready),
		.req_prim_thread_id(req_prim_thread_id), .req_back_facing(req_back_facing),
		.req_viewport_index(req_viewport_index), .req_array_index(req_array_index),
		.disp_valid(disp_valid), .disp_ready(disp_ready), .disp_header(disp_header),
		.first_sample_pair_index(first_sample_pair_index),
		.thread_resource_tag(thread_resource_tag), .slot_group_subspan(slot_group_subspan),
		.slot_group_sample(slot_group_sample), .disp_payload_regs(disp_payload_regs),
		.disp_depth_reg(disp_depth_reg), .disp_w_reg(disp_w_reg));
	pspb_disp_sink pspb_disp_sink_inst (.pclk(pclk), .presetn(presetn),
		.disp_valid(disp_valid), .stall(stall), .disp_ready(disp_ready));

	always #2 pclk = ~pclk;

	// ==========================================================
	// reporting
	task conclude;
		$display("compared %0d, mismatched %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task timeout;
		n_errors++;
		$display("FAIL %0t wait ran out", $time);
		conclude();
	endtask : timeout

	// ==========================================================
	// apb master: request held until pready sampled high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			timeout();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// ==========================================================
	// windower side: request held until accepted
	task send_req(input logic [23:0] p, input logic b, input logic [3:0] v,
		input logic [10:0] a);
		int n;
		@(posedge pclk);
		req_valid <= 1'b1;
		req_prim_thread_id <= p;
		req_back_facing <= b;
		req_viewport_index <= v;
		req_array_index <= a;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (req_ready !== 1'b1 && n < 100);
		if (n >= 100)
			timeout();
		req_valid <= 1'b0;
	endtask : send_req

	// ==========================================================
	// one request in a given width and sample count
	task run_mode(input logic w, input logic [2:0] ns);
		logic [31:0] ctrl, h0;
		logic [2:0]  pair;
		logic [3:0]  smp;
		logic [1:0]  ssb;
		logic        e;
		int          per, dr, tot, cnt, k, n;
		per = w ? 2 : 1;
		dr = w ? 10 : 2;
		tot = dr + per;
		cnt = w ? ((ns < 3) ? 1 : (1 << (ns - 2))) : ((ns < 2) ? 1 : (1 << (ns - 1)));
		ctrl = {17'h0, !w, w, (w ? 6'h21 : 6'h00), !w, w, 1'b0, ns, w};
		stall <= {1'b0, ns};
		apb(1'b1, `PSPB_ADDR_CTRL, ctrl, e);
		apb(1'b0, `PSPB_ADDR_CTRL, 32'h0, e);
		check(rd, ctrl, "ctrl readback");
		apb(1'b0, `PSPB_ADDR_STATUS, 32'h0, e);
		check(rd[13:8], tot, "status regs");
		send_req({20'hfedcb, 1'b0, ns}, ns[0], 4'hf - {1'b0, ns}, 11'h7ff - ns);
		k = 0;
		n = 0;
		while (k < cnt)
		begin
			@(negedge pclk);
			n++;
			if (n > 400)
				timeout();
			if (disp_valid === 1'b1 && disp_ready === 1'b1)
			begin
				pair = 3'(k * per);
				check(first_sample_pair_index, pair, "pair index");
				for (int g = 0; g < 4; g++)
				begin
					if (ns == 0)
					begin
						ssb = 2'(g);
						smp = 4'h0;
					end
					else if (ns == 1)
					begin
						ssb = 2'(g >> 1);
						smp = 4'(g & 1);
					end
					else
					begin
						ssb = 2'h0;
						smp = 4'({pair, 1'b0}) + 4'(g);
					end
					if (!w && g > 1)
					begin
						ssb = 2'h0;
						smp = 4'h0;
					end
					check({slot_group_subspan[g], slot_group_sample[g]}, {ssb, smp}, "slots");
				end
				check(disp_header[7], {8'h0, 20'hfedcb, 1'b0, ns}, "dw7");
				check(disp_header[6], {8'h0, 24'(exp_tid)}, "dw6");
				check(disp_header[5], 32'h1357_9800 | {24'h0, 8'(exp_tid)}, "dw5");
				check(thread_resource_tag, 8'(exp_tid), "tag");
				check(disp_header[4], 32'h0246_8ae0, "dw4");
				check(disp_header[3], 32'habcd_ef2b, "dw3");
				check(disp_header[2], 32'h0, "dw2");
				check(disp_header[1], 32'h1234_5640, "dw1");
				h0 = {1'b0, 4'hf - {1'b0, ns}, 11'h7ff - ns, ns[0], 1'b0, w, !w, 4'h0, pair[1:0], 6'h0};
				check(disp_header[0], h0, "dw0");
				check(disp_payload_regs, tot, "payload regs");
				check(w ? disp_depth_reg : disp_w_reg, dr, "phase start");
				exp_tid++;
				k++;
			end
		end
		repeat (3) @(negedge pclk);
		check({disp_valid, req_ready}, 2'b01, "no extra dispatch");
		$display("test wide=%0d samples_log2=%0d done", w, ns);
	endtask : run_mode

	// ==========================================================
	// main sequence
	initial
	begin : main
		logic e;
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{req_valid, req_back_facing, req_prim_thread_id} = '0;
		{req_viewport_index, req_array_index, stall} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `PSPB_ADDR_CTRL, 32'h0, e);
		check(rd, `PSPB_CTRL_RESET, "ctrl reset");
		check({disp_valid, req_ready}, 2'b01, "idle after reset");
		apb(1'b1, `PSPB_ADDR_CC_PTR, 32'h1234_567f, e);
		apb(1'b1, `PSPB_ADDR_SAMP_PTR, 32'habcd_ef2f, e);
		apb(1'b1, `PSPB_ADDR_BIND_PTR, 32'h0246_8aff, e);
		apb(1'b1, `PSPB_ADDR_SCR_PTR, 32'h1357_9bff, e);
		apb(1'b0, `PSPB_ADDR_SAMP_PTR, 32'h0, e);
		check(rd[3:0], `PSPB_SCRATCH_MAX, "scratch code saturates");
		$display("test reset and pointers done");
		for (int wi = 0; wi < 2; wi++)
			for (int ni = 0; ni < 5; ni++)
				run_mode(wi[0], 3'(ni));
		// contiguous requests are consumed with no dispatch
		apb(1'b1, `PSPB_ADDR_CTRL, 32'h0000_0010, e);
		send_req(24'h000001, 1'b0, 4'h0, 11'h0);
		repeat (5) @(negedge pclk);
		check(disp_valid, 1'b0, "contiguous dispatch");
		apb(1'b0, `PSPB_ADDR_STATUS, 32'h0, e);
		check(rd[1], 1'b1, "refused flag");
		apb(1'b1, `PSPB_ADDR_STATUS, 32'h0000_0002, e);
		apb(1'b0, `PSPB_ADDR_STATUS, 32'h0, e);
		check(rd[1], 1'b0, "refused cleared");
		apb(1'b0, `PSPB_ADDR_THREAD, 32'h0, e);
		check(rd, 32'(exp_tid), "thread count");
		apb(1'b0, 12'h01c, 32'h0, e);
		check(e, 1'b1, "unmapped error");
		check(rd, 32'h0, "unmapped read");
		$display("test contiguous and status done");
		conclude();
	end
endmodule : tb
